//--- hw/hio_pkg.sv
// Constants shared by the handler I/O port block.
// Assumes a single 50 MHz clock and a word-wide classic Wishbone slave.
package hio_pkg;

   // ********
   // Timing
   // ********
   localparam int CLK_MHZ = 50;
   localparam int MEASURE_TRIGGER_N_MIN_US = 100;
   localparam int MEASURE_TRIGGER_N_MIN_CYC = MEASURE_TRIGGER_N_MIN_US * CLK_MHZ;
   localparam int ACQ_RESP_MAX_US = 200;
   localparam int ACQ_RESP_MAX_CYC = ACQ_RESP_MAX_US * CLK_MHZ;

   // ********
   // Register byte offsets
   // ********
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_IRQ_STAT = 8'h08;
   localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
   localparam logic [7:0] REG_VSET = 8'h10;
   localparam logic [7:0] REG_PANEL = 8'h14;

   // ********
   // Control fields and reset values
   // ********
   localparam int CTRL_EXT_MEASURE_TRIGGER_N = 0;
   localparam int CTRL_SORT_MODE = 1;
   localparam int CTRL_CLR_ON_START = 2;
   localparam int CTRL_SYNC_OUT = 3;
   localparam int CTRL_SOFT_MEASURE_TRIGGER_N = 4;
   localparam logic [3:0] CTRL_RESET = 4'h4;
   localparam logic [15:0] VSET_RESET = 16'h03E8;

   // ********
   // Status and interrupt fields
   // ********
   localparam int STAT_LEVEL_FAULT = 2;
   localparam int STAT_ACQ_BUSY = 3;
   localparam int STAT_MEAS_BUSY = 4;
   localparam int IRQ_MEASURE_TRIGGER_N_TAKEN = 0;
   localparam int IRQ_ACQ_DONE = 1;
   localparam int IRQ_MEAS_DONE = 2;
   localparam int IRQ_LEVEL_FAULT = 3;
   localparam int IRQ_MEASURE_TRIGGER_N_IGNORED = 4;
   localparam int IRQ_W = 5;
   localparam int PANEL_ACTIVE_LSB = 8;

   // ********
   // Judgment codes from the measurement engine
   // ********
   localparam logic [1:0] JUDGE_NONE = 2'h0;
   localparam logic [1:0] JUDGE_HI = 2'h1;
   localparam logic [1:0] JUDGE_IN = 2'h2;
   localparam logic [1:0] JUDGE_LO = 2'h3;

   localparam int PANEL_W = 7;
   localparam int CLASS_LINES = 14;
   localparam int LEVEL_TOL_DIV = 10;

   typedef enum {ST_IDLE, ST_ACQ, ST_CALC} hio_state_e;

endpackage

//--- hw/hio_judge_if.sv
// Judgment bundle between the port top and its line encoder.
// Assumes both ends sit in the same clock domain; content is combinational.
interface hio_judge_if;
   logic sort_mode;
   logic pri_judged;
   logic sec_judged;
   logic [1:0] pri_code;
   logic [1:0] sec_code;
   logic [3:0] bin_class;
   logic unsorted;
   logic reject;
   logic [hio_pkg::CLASS_LINES-1:0] lines;
   logic unsorted_line;
   logic reject_line;

   modport src
   (
      output sort_mode, pri_judged, sec_judged, pri_code, sec_code, bin_class, unsorted, reject,
      input lines, unsorted_line, reject_line
   );

   modport enc
   (
      input sort_mode, pri_judged, sec_judged, pri_code, sec_code, bin_class, unsorted, reject,
      output lines, unsorted_line, reject_line
   );
endinterface

//--- hw/hio_judge_enc.sv
// Maps comparator or sort-class judgments onto the shared result lines.
// Assumes the caller registers and inverts the active-high lines it returns.
module hio_judge_enc
(
   // Judgment bundle
   hio_judge_if.enc jdg
);
   logic pri_in;
   logic sec_in;
   logic pass;

   assign pri_in = jdg.pri_code == hio_pkg::JUDGE_IN;
   assign sec_in = jdg.sec_code == hio_pkg::JUDGE_IN;

   // Only the parameters actually judged take part in the combined pass
   assign pass = (jdg.pri_judged || jdg.sec_judged)
      && (!jdg.pri_judged || pri_in) && (!jdg.sec_judged || sec_in);

   always_comb
   begin
      jdg.lines = '0;
      jdg.unsorted_line = 1'b0;
      jdg.reject_line = 1'b0;
      if (jdg.sort_mode)
      begin
         for (int k = 0; k < hio_pkg::CLASS_LINES; k++)
         begin
            jdg.lines[k] = jdg.bin_class == 4'(k + 1);
         end
         jdg.unsorted_line = jdg.unsorted;
         jdg.reject_line = jdg.reject;
      end
      else
      begin
         // One code per parameter keeps over, in and under exclusive
         jdg.lines[0] = jdg.pri_judged && jdg.pri_code == hio_pkg::JUDGE_HI;
         jdg.lines[1] = jdg.pri_judged && pri_in;
         jdg.lines[2] = jdg.pri_judged && jdg.pri_code == hio_pkg::JUDGE_LO;
         jdg.lines[3] = jdg.sec_judged && jdg.sec_code == hio_pkg::JUDGE_HI;
         jdg.lines[4] = jdg.sec_judged && sec_in;
         jdg.lines[5] = jdg.sec_judged && jdg.sec_code == hio_pkg::JUDGE_LO;
         jdg.lines[6] = pass;
      end
   end
endmodule // hio_judge_enc

//--- hw/hio_measure_trigger_n_qual.sv
// Qualifies the active-low trigger line by its minimum low width.
// Assumes the line is already synchronous to clk_i.
module hio_measure_trigger_n_qual #(
   parameter int MIN_CYC = hio_pkg::MEASURE_TRIGGER_N_MIN_CYC
)
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Trigger line and qualifiers
   input wire logic measure_trigger_n_n_i,
   input wire logic enable_i,
   input wire logic busy_i,
   // Results
   output logic fire_o,
   output logic ignored_o
);
   localparam int CW = $clog2(MIN_CYC + 1);
   logic [CW-1:0] cnt_ff;
   logic used_ff;
   logic reached;

   assign reached = cnt_ff == CW'(MIN_CYC - 1);

   always_ff @(posedge clk_i)
   begin
      if (rst_i || measure_trigger_n_n_i || !enable_i)
      begin
         cnt_ff <= '0;
      end
      else if (!reached)
      begin
         cnt_ff <= cnt_ff + CW'(1);
      end
   end

   // One low pulse gives at most one decision; release rearms
   always_ff @(posedge clk_i)
   begin
      if (rst_i || measure_trigger_n_n_i || !enable_i)
      begin
         used_ff <= 1'b0;
      end
      else if (reached)
      begin
         used_ff <= 1'b1;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         fire_o <= 1'b0;
         ignored_o <= 1'b0;
      end
      else
      begin
         fire_o <= !measure_trigger_n_n_i && enable_i && reached && !used_ff && !busy_i;
         ignored_o <= !measure_trigger_n_n_i && enable_i && reached && !used_ff && busy_i;
      end
   end
endmodule // hio_measure_trigger_n_qual

//--- hw/hio_port.sv
// Handler-side digital I/O port: trigger, panel select, judgment lines.
// Assumes a measurement engine that reports analog and full completion
// and a classic Wishbone master for configuration.
//
// Contract
// - All handler trigger, select and result lines active low
// - Trigger low 100 us starts one measurement
// - Trigger ignored while analog acquisition runs
// - Panel select is seven-bit binary number
// - Trigger loads selected panel for measurement
// - Panel number accepted only while strobe asserted
// - Primary over, in, under exclusive outputs
// - Secondary over, in, under exclusive outputs
// - Combined pass when every judged parameter in
// - Fourteen classes, unsorted and reject outputs
// - Analog-done asserted when acquisition finishes
// - Measurement-done asserted when judgments valid
// - Level fault beyond ten percent of set
// - Judgments cleared at start or held
// - Analog-done drops within 200 us of trigger; not timed here, drops whenever analog_done_i arrives
module hio_port #(
   parameter int MEASURE_TRIGGER_N_MIN_CYC = hio_pkg::MEASURE_TRIGGER_N_MIN_CYC
)
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic irq_o,
   // Handler inputs, active low
   input wire logic measure_trigger_n_i,
   input wire logic [hio_pkg::PANEL_W-1:0] panel_sel_n_i,
   input wire logic panel_sel_strobe_n_i,
   // Handler outputs, active low
   output logic [hio_pkg::CLASS_LINES-1:0] class_line_n_o,
   output logic unsorted_flag_n_o,
   output logic loss_reject_n_o,
   output logic acq_done_n_o,
   output logic measure_done_n_o,
   output logic level_fault_n_o,
   // Measurement engine side
   output logic meas_start_o,
   output logic [hio_pkg::PANEL_W-1:0] meas_panel_o,
   output logic sync_out_en_o,
   input wire logic analog_done_i,
   input wire logic meas_done_i,
   input wire logic pri_judged_i,
   input wire logic sec_judged_i,
   input wire logic [1:0] pri_code_i,
   input wire logic [1:0] sec_code_i,
   input wire logic [3:0] bin_class_i,
   input wire logic unsorted_i,
   input wire logic reject_i,
   input wire logic vmeas_valid_i,
   input wire logic [15:0] vmeas_i
);

   // ********
   // Helpers
   // ********
   function automatic logic [31:0] merge_sel(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] sel);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++)
      begin
         if (sel[b])
         begin
            r[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return r;
   endfunction

   // Deviation strictly above one tenth of the set level, either side
   function automatic logic level_bad(input logic [15:0] meas, input logic [15:0] set);
      logic [15:0] diff;
      logic [19:0] scaled;
      diff = (meas > set) ? meas - set : set - meas;
      scaled = 20'(diff) * 20'(hio_pkg::LEVEL_TOL_DIV);
      return scaled > 20'(set);
   endfunction

   // ********
   // Bus decode
   // ********
   logic req;
   logic wr;
   logic [3:0] ctrl_ff;
   logic [15:0] vset_ff;
   logic [hio_pkg::IRQ_W-1:0] irq_stat_ff;
   logic [hio_pkg::IRQ_W-1:0] irq_mask_ff;
   logic [hio_pkg::IRQ_W-1:0] irq_evt;
   logic [hio_pkg::PANEL_W-1:0] panel_lat_ff;
   logic level_ff;
   logic soft_measure_trigger_n_ff;
   hio_pkg::hio_state_e state_ff;
   logic [31:0] nxt_rdata;
   logic [31:0] wr_merged;

   assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr = req && wb_we_i;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wb_ack_o <= 1'b0;
      end
      else
      begin
         wb_ack_o <= req;
      end
   end

   always_comb
   begin
      nxt_rdata = 32'h0000_0000;
      if (wb_adr_i == hio_pkg::REG_CTRL)
      begin
         nxt_rdata[3:0] = ctrl_ff;
      end
      else if (wb_adr_i == hio_pkg::REG_STATUS)
      begin
         nxt_rdata[1:0] = 2'(state_ff);
         nxt_rdata[hio_pkg::STAT_LEVEL_FAULT] = level_ff;
         nxt_rdata[hio_pkg::STAT_ACQ_BUSY] = state_ff == hio_pkg::ST_ACQ;
         nxt_rdata[hio_pkg::STAT_MEAS_BUSY] = state_ff != hio_pkg::ST_IDLE;
      end
      else if (wb_adr_i == hio_pkg::REG_IRQ_STAT)
      begin
         nxt_rdata[hio_pkg::IRQ_W-1:0] = irq_stat_ff;
      end
      else if (wb_adr_i == hio_pkg::REG_IRQ_MASK)
      begin
         nxt_rdata[hio_pkg::IRQ_W-1:0] = irq_mask_ff;
      end
      else if (wb_adr_i == hio_pkg::REG_VSET)
      begin
         nxt_rdata[15:0] = vset_ff;
      end
      else if (wb_adr_i == hio_pkg::REG_PANEL)
      begin
         nxt_rdata[hio_pkg::PANEL_W-1:0] = panel_lat_ff;
         nxt_rdata[hio_pkg::PANEL_ACTIVE_LSB +: hio_pkg::PANEL_W] = meas_panel_o;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wb_dat_o <= 32'h0000_0000;
      end
      else if (req && !wb_we_i)
      begin
         wb_dat_o <= nxt_rdata;
      end
   end

   // ********
   // Configuration registers
   // ********
   always_comb
   begin
      wr_merged = 32'h0000_0000;
      if (wb_adr_i == hio_pkg::REG_CTRL)
      begin
         wr_merged = merge_sel({28'h0, ctrl_ff}, wb_dat_i, wb_sel_i);
      end
      else if (wb_adr_i == hio_pkg::REG_VSET)
      begin
         wr_merged = merge_sel({16'h0, vset_ff}, wb_dat_i, wb_sel_i);
      end
      else if (wb_adr_i == hio_pkg::REG_IRQ_MASK)
      begin
         wr_merged = merge_sel({27'h0, irq_mask_ff}, wb_dat_i, wb_sel_i);
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ctrl_ff <= hio_pkg::CTRL_RESET;
      end
      else if (wr && wb_adr_i == hio_pkg::REG_CTRL)
      begin
         ctrl_ff <= wr_merged[3:0];
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         soft_measure_trigger_n_ff <= 1'b0;
      end
      else
      begin
         soft_measure_trigger_n_ff <= wr && wb_adr_i == hio_pkg::REG_CTRL
            && wr_merged[hio_pkg::CTRL_SOFT_MEASURE_TRIGGER_N];
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         vset_ff <= hio_pkg::VSET_RESET;
      end
      else if (wr && wb_adr_i == hio_pkg::REG_VSET)
      begin
         vset_ff <= wr_merged[15:0];
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         irq_mask_ff <= '0;
      end
      else if (wr && wb_adr_i == hio_pkg::REG_IRQ_MASK)
      begin
         irq_mask_ff <= wr_merged[hio_pkg::IRQ_W-1:0];
      end
   end

   // ********
   // Trigger and panel select
   // ********
   logic ext_fire;
   logic ext_ignored;
   logic start;
   logic soft_ok;

   hio_measure_trigger_n_qual #(
      .MIN_CYC(MEASURE_TRIGGER_N_MIN_CYC)
   ) u_measure_trigger_n (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .measure_trigger_n_n_i(measure_trigger_n_i),
      .enable_i(ctrl_ff[hio_pkg::CTRL_EXT_MEASURE_TRIGGER_N]),
      .busy_i(state_ff == hio_pkg::ST_ACQ),
      .fire_o(ext_fire),
      .ignored_o(ext_ignored)
   );

   // Soft trigger serves internal mode and is also held off by acquisition
   assign soft_ok = soft_measure_trigger_n_ff && !ctrl_ff[hio_pkg::CTRL_EXT_MEASURE_TRIGGER_N]
      && state_ff != hio_pkg::ST_ACQ;
   assign start = ext_fire || soft_ok;

   // Binary weights: bit k counts 2**k
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         panel_lat_ff <= '0;
      end
      else if (!panel_sel_strobe_n_i)
      begin
         panel_lat_ff <= ~panel_sel_n_i;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         meas_panel_o <= '0;
      end
      else if (ext_fire)
      begin
         meas_panel_o <= panel_lat_ff;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         meas_start_o <= 1'b0;
         sync_out_en_o <= 1'b0;
      end
      else
      begin
         meas_start_o <= start;
         sync_out_en_o <= ctrl_ff[hio_pkg::CTRL_SYNC_OUT];
      end
   end

   // ********
   // Measurement sequence
   // ********
   // A fresh start during calculation restarts the cycle; the handler is
   // allowed to trigger again once done is seen, with no gap
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_ff <= hio_pkg::ST_IDLE;
      end
      else
      begin
         case (state_ff)
            hio_pkg::ST_IDLE:
            begin
               if (start)
               begin
                  state_ff <= hio_pkg::ST_ACQ;
               end
            end
            hio_pkg::ST_ACQ:
            begin
               if (analog_done_i)
               begin
                  state_ff <= hio_pkg::ST_CALC;
               end
            end
            default:
            begin
               if (start)
               begin
                  state_ff <= hio_pkg::ST_ACQ;
               end
               else if (meas_done_i)
               begin
                  state_ff <= hio_pkg::ST_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         acq_done_n_o <= 1'b0;
      end
      else if (start)
      begin
         acq_done_n_o <= 1'b1;
      end
      else if (state_ff == hio_pkg::ST_ACQ && analog_done_i)
      begin
         acq_done_n_o <= 1'b0;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         measure_done_n_o <= 1'b0;
      end
      else if (start)
      begin
         measure_done_n_o <= 1'b1;
      end
      else if (state_ff == hio_pkg::ST_CALC && meas_done_i)
      begin
         measure_done_n_o <= 1'b0;
      end
   end

   // ********
   // Judgment lines
   // ********
   hio_judge_if jdg ();

   assign jdg.sort_mode = ctrl_ff[hio_pkg::CTRL_SORT_MODE];
   assign jdg.pri_judged = pri_judged_i;
   assign jdg.sec_judged = sec_judged_i;
   assign jdg.pri_code = pri_code_i;
   assign jdg.sec_code = sec_code_i;
   assign jdg.bin_class = bin_class_i;
   assign jdg.unsorted = unsorted_i;
   assign jdg.reject = reject_i;

   hio_judge_enc u_enc (
      .jdg(jdg.enc)
   );

   // Lines idle high; results change only at start (if clearing) or done
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         class_line_n_o <= '1;
         unsorted_flag_n_o <= 1'b1;
         loss_reject_n_o <= 1'b1;
      end
      else if (start && ctrl_ff[hio_pkg::CTRL_CLR_ON_START])
      begin
         class_line_n_o <= '1;
         unsorted_flag_n_o <= 1'b1;
         loss_reject_n_o <= 1'b1;
      end
      else if (state_ff == hio_pkg::ST_CALC && meas_done_i && !start)
      begin
         class_line_n_o <= ~jdg.lines;
         unsorted_flag_n_o <= ~jdg.unsorted_line;
         loss_reject_n_o <= ~jdg.reject_line;
      end
   end

   // ********
   // Test level check
   // ********
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         level_ff <= 1'b0;
      end
      else if (vmeas_valid_i)
      begin
         level_ff <= level_bad(vmeas_i, vset_ff);
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         level_fault_n_o <= 1'b1;
      end
      else
      begin
         level_fault_n_o <= !(vmeas_valid_i ? level_bad(vmeas_i, vset_ff) : level_ff);
      end
   end

   // ********
   // Interrupts
   // ********
   always_comb
   begin
      irq_evt = '0;
      irq_evt[hio_pkg::IRQ_MEASURE_TRIGGER_N_TAKEN] = start;
      irq_evt[hio_pkg::IRQ_ACQ_DONE] = state_ff == hio_pkg::ST_ACQ && analog_done_i;
      irq_evt[hio_pkg::IRQ_MEAS_DONE] = state_ff == hio_pkg::ST_CALC && meas_done_i && !start;
      irq_evt[hio_pkg::IRQ_LEVEL_FAULT] = vmeas_valid_i && level_bad(vmeas_i, vset_ff) && !level_ff;
      irq_evt[hio_pkg::IRQ_MEASURE_TRIGGER_N_IGNORED] = ext_ignored
         || (soft_measure_trigger_n_ff && !soft_ok && !ctrl_ff[hio_pkg::CTRL_EXT_MEASURE_TRIGGER_N]);
   end

   // Set beats a simultaneous write-one clear so no event is lost
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         irq_stat_ff <= '0;
      end
      else if (wr && wb_adr_i == hio_pkg::REG_IRQ_STAT && wb_sel_i[0])
      begin
         irq_stat_ff <= (irq_stat_ff & ~wb_dat_i[hio_pkg::IRQ_W-1:0]) | irq_evt;
      end
      else
      begin
         irq_stat_ff <= irq_stat_ff | irq_evt;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         irq_o <= 1'b0;
      end
      else
      begin
         irq_o <= |((irq_stat_ff | irq_evt) & irq_mask_ff);
      end
   end

endmodule // hio_port

//--- tb/hio_port_properties.sv
// Concurrent checks on the handler I/O port outputs.
// Assumes one clock domain; bound to every hio_port instance.
module hio_port_props
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   // Handler and engine
   input wire logic [hio_pkg::CLASS_LINES-1:0] class_line_n_o,
   input wire logic acq_done_n_o,
   input wire logic measure_done_n_o,
   input wire logic meas_start_o,
   input wire logic analog_done_i,
   input wire logic meas_done_i
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // ********
   // Properties
   // ********
   pri_excl_a: assert property ($onehot0(~class_line_n_o[2:0]))
      else $error("primary lines overlap");
   sec_excl_a: assert property ($onehot0(~class_line_n_o[5:3]))
      else $error("secondary lines overlap");
   start_pulse_a: assert property (meas_start_o |=> !meas_start_o)
      else $error("start longer than one cycle");
   start_flags_a: assert property (meas_start_o |-> acq_done_n_o && measure_done_n_o)
      else $error("done flags not raised at start");
   start_idle_a: assert property (meas_start_o |-> !$past(acq_done_n_o))
      else $error("start during acquisition");
   acq_end_a: assert property (acq_done_n_o && analog_done_i |=> !acq_done_n_o)
      else $error("analog done not shown");
   meas_end_a: assert property (measure_done_n_o && !acq_done_n_o && meas_done_i |=> !measure_done_n_o)
      else $error("measurement done not shown");
   result_hold_a: assert property ($fell(measure_done_n_o) |=> $stable(class_line_n_o))
      else $error("results moved after done");
   ack_resp_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
      else $error("bus answer malformed");
endmodule // hio_port_props

bind hio_port hio_port_props u_props (.*);

//--- tb/hio_handler_model.sv
// Handler model: panel strobe and active-low trigger of fixed width.
// Assumes go_i is a one-cycle pulse while busy_o is low.
module hio_handler_model #(
   parameter int LOW_CYC = 8
)
(
   // Clock and command
   input wire logic clk_i,
   input wire logic go_i,
   input wire logic [6:0] panel_i,
   // Handler lines
   output logic measure_trigger_n_n_o,
   output logic [6:0] panel_n_o,
   output logic strobe_n_o,
   output logic busy_o
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt = 0;
   initial
   begin
      measure_trigger_n_n_o = 1'b1;
      strobe_n_o = 1'b1;
      panel_n_o = 7'h00;
   end
   assign busy_o = cnt != 0;
   always @(posedge clk_i)
   begin
      if (cnt == 0 && go_i)
         cnt <= LOW_CYC + 2;
      else if (cnt != 0)
         cnt <= cnt - 1;
      strobe_n_o <= !(go_i || cnt > 1);
      // Lines wander while not valid so a stale latch shows up
      panel_n_o <= (go_i || cnt > 1) ? ~panel_i : panel_n_o + 7'h01;
      measure_trigger_n_n_o <= !(cnt > 1 && cnt <= LOW_CYC + 1);
   end
endmodule // hio_handler_model

//--- tb/tb.sv
// Self-checking bench for the handler I/O port.
// Assumes the trigger width parameter is shortened to 8 cycles.
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o, go, busy, done_q;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i, bin_class_i;
   logic [31:0] wb_dat_i, wb_dat_o;
   logic measure_trigger_n_i, panel_sel_strobe_n_i, unsorted_flag_n_o, loss_reject_n_o;
   logic [6:0] panel_sel_n_i, meas_panel_o, pn;
   logic [13:0] class_line_n_o;
   logic acq_done_n_o, measure_done_n_o, level_fault_n_o, meas_start_o, sync_out_en_o;
   logic analog_done_i, meas_done_i, pri_judged_i, sec_judged_i, unsorted_i, reject_i;
   logic vmeas_valid_i;
   logic [1:0] pri_code_i, sec_code_i;
   logic [15:0] vmeas_i, r, prev, e;
   logic [15:0] lv [4] = '{16'h044D, 16'h044C, 16'h0383, 16'h0384};
   logic [31:0] rd_q [$];
   logic [15:0] res_q [$];
   int n_errors = 0;
   int n_tests = 0;
   int cyc_n = 0;

   hio_port #(.MEASURE_TRIGGER_N_MIN_CYC(8)) u_dut (.*);
   hio_handler_model #(.LOW_CYC(8)) u_hand (.clk_i, .go_i(go), .panel_i(pn),
      .measure_trigger_n_n_o(measure_trigger_n_i), .panel_n_o(panel_sel_n_i),
      .strobe_n_o(panel_sel_strobe_n_i), .busy_o(busy));

   initial
   begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end

   // ********
   // Helpers
   // ********
   function logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function logic [1:0] jcode(input logic j, input logic [1:0] x);
      return j ? (x == 2'h0 ? hio_pkg::JUDGE_IN : x) : hio_pkg::JUDGE_NONE;
   endfunction
   function logic [15:0] cmp_exp(input logic pj, sj, input logic [1:0] pc, sc);
      logic pin, sin;
      pin = pc == hio_pkg::JUDGE_IN;
      sin = sc == hio_pkg::JUDGE_IN;
      return ~{9'h000, (pj | sj) & (!pj | pin) & (!sj | sin), sc == hio_pkg::JUDGE_LO, sin,
         sc == hio_pkg::JUDGE_HI, pc == hio_pkg::JUDGE_LO, pin, pc == hio_pkg::JUDGE_HI};
   endfunction
   task give_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         $display("wrong value at %0t: got %h exp %h", $time, got, exp);
         n_errors++;
      end
   endtask
   // Reads pass the expected word in d
   task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      if (!we)
         rd_q.push_back(d);
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task go_hand(input logic [6:0] p);
      pn <= p;
      go <= 1'b1;
      @(posedge clk_i);
      go <= 1'b0;
   endtask
   // Plays the measurement engine for one start
   task meas(input logic ext, ign, clr, input logic [6:0] p);
      do @(posedge clk_i); while (meas_start_o !== 1'b1);
      if (ext)
         chk(meas_panel_o, p);
      repeat (2) @(posedge clk_i);
      chk({unsorted_flag_n_o, loss_reject_n_o, class_line_n_o}, clr ? 16'hFFFF : prev);
      if (ign)
      begin
         go_hand(p);
         repeat (14) @(posedge clk_i);
      end
      analog_done_i <= 1'b1;
      @(posedge clk_i);
      analog_done_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      meas_done_i <= 1'b1;
      res_q.push_back(e);
      @(posedge clk_i);
      meas_done_i <= 1'b0;
      prev = e;
      repeat (3) @(posedge clk_i);
   endtask

   // ********
   // Monitor and timeout
   // ********
   always @(posedge clk_i)
   begin
      done_q <= measure_done_n_o;
      if (wb_ack_o && !wb_we_i && rd_q.size() > 0)
         chk(wb_dat_o, rd_q.pop_front());
      if (done_q && !measure_done_n_o && res_q.size() > 0)
         chk({unsorted_flag_n_o, loss_reject_n_o, class_line_n_o}, res_q.pop_front());
      cyc_n++;
      if (cyc_n == 20000)
      begin
         n_errors++;
         give_verdict;
      end
   end

   initial
   begin
      int i;
      logic clr, srt;
      logic [6:0] p;
      {wb_cyc_i, wb_stb_i, wb_we_i, analog_done_i, meas_done_i, vmeas_valid_i, go} = '0;
      {pri_judged_i, sec_judged_i, pri_code_i, sec_code_i, bin_class_i, unsorted_i} = '0;
      {reject_i, wb_adr_i, wb_dat_i, vmeas_i, pn, done_q} = '0;
      wb_sel_i = 4'hF;
      r = 16'h1F18;
      prev = 16'hFFFF;
      rst_i = 1'b1;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      chk({sync_out_en_o, acq_done_n_o, measure_done_n_o, level_fault_n_o, unsorted_flag_n_o,
         loss_reject_n_o, class_line_n_o}, 32'h0001FFFF);
      wb(1'b0, hio_pkg::REG_CTRL, 32'h00000004);
      wb(1'b0, hio_pkg::REG_VSET, 32'h000003E8);
      wb(1'b0, 8'h1C, 32'h00000000);
      wb(1'b1, hio_pkg::REG_IRQ_STAT, 32'h0000001F);
      $display("test done: reset values");
      for (i = 0; i < 20; i++)
      begin
         r = lfsr(r);
         srt = i > 4;
         // Mode change must not meet held lines of the other mode
         clr = r[4] | (i == 5);
         p = i == 0 ? 7'h63 : r[14:8];
         pri_judged_i <= r[0];
         sec_judged_i <= r[1];
         pri_code_i <= jcode(r[0], r[3:2]);
         sec_code_i <= jcode(r[1], r[6:5]);
         bin_class_i <= srt ? 4'(i - 5) : r[11:8];
         unsorted_i <= r[7];
         reject_i <= r[12];
         if (srt)
            e = {~r[7], ~r[12], i == 5 ? 14'h3FFF : ~(14'h0001 << (i - 6))};
         else
            e = cmp_exp(r[0], r[1], jcode(r[0], r[3:2]), jcode(r[1], r[6:5]));
         wb(1'b1, hio_pkg::REG_CTRL, 32'({clr, srt, !srt}));
         if (srt)
            wb(1'b1, hio_pkg::REG_CTRL, 32'({2'b10, clr, srt, 1'b0}));
         else
            go_hand(p);
         meas(!srt, i == 1, clr, p);
         if (i == 1)
         begin
            wb(1'b0, hio_pkg::REG_IRQ_STAT, 32'h00000017);
            wb(1'b1, hio_pkg::REG_IRQ_MASK, 32'h00000010);
            repeat (2) @(posedge clk_i);
            chk(32'(irq_o), 32'h00000001);
            wb(1'b1, hio_pkg::REG_IRQ_STAT, 32'h00000010);
            repeat (2) @(posedge clk_i);
            chk(32'(irq_o), 32'h00000000);
            $display("test done: ignored trigger and interrupt");
         end
      end
      $display("test done: judgment lines");
      for (i = 0; i < 4; i++)
      begin
         vmeas_i <= lv[i];
         vmeas_valid_i <= 1'b1;
         @(posedge clk_i);
         vmeas_valid_i <= 1'b0;
         @(posedge clk_i);
         chk(32'(level_fault_n_o), 32'(i[0]));
      end
      $display("test done: level fault");
      chk(32'(rd_q.size() + res_q.size()), 32'h00000000);
      give_verdict;
   end
endmodule // tb
